// file: verilog/qug_global_ctrl.sv
// device-wide control registers of the quad uart
//
// Overview of operation
// RULE_01 - writing one resets that channel's registers, bit then self-clears
// RULE_02 - reset bit n targets channel n, bits zero to three
// RULE_03 - sleep only when idle, divisors set, all enabled, no deltas
// RULE_04 - oscillator is halted while asleep
// RULE_05 - wake on rx start edge, transmit load or modem input change
// RULE_06 - re-enter sleep automatically once everything is serviced
// RULE_07 - host reads modem status to clear a modem wake cause
// RULE_08 - uart is fully usable 32 crystal clocks after wake
// RULE_09 - wake raises a special interrupt, cleared by summary byte read
// RULE_10 - sleep enable holds one bit per channel, upper bits reserved
// RULE_11 - ident byte: series in upper nibble, channel count lower
// RULE_12 - revision byte, code rises by one per revision letter
// RULE_13 - broadcast bit makes config writes reach all four channels
// RULE_14 - write-only bits 20..22 drive eeprom clock, select and data
// RULE_15 - bit 23 reads eeprom data pin, bits 17..19 reserved
// RULE_16 - each pin: input invert and interrupt, or output high/low/off
// RULE_17 - all pin interrupts are ORed into one request on channel 0
// RULE_18 - pin register bit n belongs to pin n
// RULE_19 - pin request shows as source code 6 on channel 0
// RULE_20 - pin request clears on a read of the pin level byte
// RULE_21 - eeprom output bits hold until rewritten, reset low
`timescale 1ns/1ps
`include "qug_params.svh"
module qug_global_ctrl #(
  parameter logic [3:0] SERIES = 4'hA, // arbitrary value
  parameter logic [7:0] REVISION = 8'h05 // arbitrary value
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [3:0] i_reg_be,
  input wire logic [31:0] i_reg_wdata,
  output logic [31:0] o_reg_rdata,
  input wire logic [3:0] i_int_summary,
  input wire logic i_summary_rd,
  input wire logic [3:0] i_divisor_nonzero,
  input wire logic [3:0] i_modem_delta,
  input wire logic [3:0] i_rx_in,
  input wire logic [3:0] i_tx_load,
  input wire logic [15:0] i_modem_in,
  input wire logic [2:0] i_ch0_src_code,
  output logic [2:0] o_ch0_src_code,
  output logic [3:0] o_chan_reset,
  output logic o_broadcast,
  output logic o_osc_run,
  output logic o_uart_ready,
  output logic o_wake_irq,
  output logic o_ee_clk,
  output logic o_ee_cs,
  output logic o_ee_dout,
  input wire logic i_ee_din,
  input wire logic [7:0] i_pin,
  output logic [7:0] o_pin_out,
  output logic [7:0] o_pin_oe,
  output logic o_pin_irq
);
  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  logic wr_ctrl, wr_ident, wr_pin, wr_sel, rd_pin_lvl;
  assign wr_ctrl = i_reg_wr && (i_reg_addr == `QUG_OFF_CTRL);
  assign wr_ident = i_reg_wr && (i_reg_addr == `QUG_OFF_IDENT);
  assign wr_pin = i_reg_wr && (i_reg_addr == `QUG_OFF_PIN);
  assign wr_sel = i_reg_wr && (i_reg_addr == `QUG_OFF_PINSEL);
  assign rd_pin_lvl = i_reg_rd && (i_reg_addr == `QUG_OFF_PIN) &&
                      i_reg_be[1];

  logic [3:0] chan_rst_q;
  logic [3:0] sleep_en_q;
  logic bcast_q;
  qug_pkg::qug_eeprom_t ee_q;
  qug_pkg::qug_pin_cfg_t pin_q;
  qug_pkg::qug_state_t state_q;
  logic [`QUG_WCNT_W-1:0] wcnt_q;
  logic wake_irq_q;
  logic pin_irq_q;
  logic [7:0] pin_act_q;
  logic [3:0] rx_prev_q;
  logic [15:0] modem_prev_q;
  logic [31:0] rdata_q;

  // ----------------------------------------------------------------
  // channel soft reset
  // ----------------------------------------------------------------
  // one-cycle pulse per written one; nothing is stored, so it reads 0
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      chan_rst_q <= 4'h0;
    end else if (wr_ctrl && i_reg_be[2]) begin
      chan_rst_q <= i_reg_wdata[19:16]; // [RULE_01] [RULE_02]
    end else begin
      chan_rst_q <= 4'h0; // [RULE_01]
    end
  end
  assign o_chan_reset = chan_rst_q;

  // ----------------------------------------------------------------
  // sleep enable, broadcast and eeprom bits
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      sleep_en_q <= `QUG_SLEEP_RST;
    end else if (wr_ctrl && i_reg_be[3]) begin
      sleep_en_q <= i_reg_wdata[27:24]; // [RULE_10]
    end
  end

  // eeprom bits only move on a write, so software bit-bangs at leisure
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      bcast_q <= 1'b0;
      ee_q <= '0; // [RULE_21]
    end else if (wr_ident && i_reg_be[2]) begin
      bcast_q <= i_reg_wdata[`QUG_BCAST_BIT]; // [RULE_13]
      ee_q.clk <= i_reg_wdata[`QUG_EE_CLK_BIT]; // [RULE_14]
      ee_q.cs <= i_reg_wdata[`QUG_EE_CS_BIT]; // [RULE_14]
      ee_q.dout <= i_reg_wdata[`QUG_EE_DO_BIT]; // [RULE_14]
    end
  end
  assign o_broadcast = bcast_q; // [RULE_13]
  assign o_ee_clk = ee_q.clk;
  assign o_ee_cs = ee_q.cs;
  assign o_ee_dout = ee_q.dout;

  // ----------------------------------------------------------------
  // multipurpose pins
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      pin_q.irq_en <= `QUG_PIN_RST;
      pin_q.level <= `QUG_PIN_RST;
      pin_q.tristate <= `QUG_PIN_RST;
      pin_q.invert <= `QUG_PIN_RST;
      pin_q.direction <= `QUG_PINSEL_RST;
    end else begin
      if (wr_pin && i_reg_be[0]) pin_q.irq_en <= i_reg_wdata[7:0];
      if (wr_pin && i_reg_be[1]) pin_q.level <= i_reg_wdata[15:8];
      if (wr_pin && i_reg_be[2]) pin_q.tristate <= i_reg_wdata[23:16];
      if (wr_pin && i_reg_be[3]) pin_q.invert <= i_reg_wdata[31:24];
      if (wr_sel && i_reg_be[0]) pin_q.direction <= i_reg_wdata[7:0];
    end
  end

  // direction bit one means input; outputs drive unless tri-stated
  logic [7:0] pin_in_lvl, pin_act, pin_rd_lvl;
  assign o_pin_out = pin_q.level; // [RULE_16] [RULE_18]
  assign o_pin_oe = ~pin_q.direction & ~pin_q.tristate; // [RULE_16]
  assign pin_in_lvl = i_pin ^ pin_q.invert; // [RULE_16]
  assign pin_act = pin_in_lvl & pin_q.irq_en & pin_q.direction;
  assign pin_rd_lvl = (pin_in_lvl & pin_q.direction) |
                      (pin_q.level & ~pin_q.direction);

  // edge sensed so a held level does not re-raise after the clearing read
  logic pin_rise;
  assign pin_rise = |(pin_act & ~pin_act_q); // [RULE_17]
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      pin_act_q <= 8'h00;
      pin_irq_q <= 1'b0;
    end else begin
      pin_act_q <= pin_act;
      if (pin_rise) begin
        pin_irq_q <= 1'b1; // [RULE_17]
      end else if (rd_pin_lvl) begin
        pin_irq_q <= 1'b0; // [RULE_20]
      end
    end
  end
  assign o_pin_irq = pin_irq_q;
  assign o_ch0_src_code = pin_irq_q ? `QUG_PIN_CODE :
                          i_ch0_src_code; // [RULE_19]

  // ----------------------------------------------------------------
  // sleep and wake
  // ----------------------------------------------------------------
  logic sleep_ok, wake_ev;
  assign sleep_ok = (i_int_summary == 4'h0) && (&i_divisor_nonzero) &&
                    (sleep_en_q == `QUG_SLEEP_ALL) &&
                    (i_modem_delta == 4'h0) && (&i_rx_in) &&
                    !wake_irq_q; // [RULE_03] [RULE_06]
  assign wake_ev = |(rx_prev_q & ~i_rx_in) || (|i_tx_load) ||
                   (i_modem_in != modem_prev_q); // [RULE_05]

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      rx_prev_q <= 4'hF;
      modem_prev_q <= 16'h0000;
    end else begin
      rx_prev_q <= i_rx_in;
      modem_prev_q <= i_modem_in;
    end
  end

  // modem wake cause stays in the channel until the host reads its
  // modem status; sleep_ok waits on the delta bits for that [RULE_07]
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_q <= qug_pkg::ST_AWAKE;
      wcnt_q <= '0;
    end else begin
      case (state_q)
        qug_pkg::ST_AWAKE: begin
          if (sleep_ok && !wake_ev) state_q <= qug_pkg::ST_ASLEEP; // [RULE_03]
        end
        qug_pkg::ST_ASLEEP: begin
          if (wake_ev) begin
            state_q <= qug_pkg::ST_WAKING; // [RULE_05]
            wcnt_q <= '0;
          end
        end
        qug_pkg::ST_WAKING: begin
          if (wcnt_q == `QUG_WCNT_W'(`QUG_WAKE_CLKS - 1)) begin
            state_q <= qug_pkg::ST_AWAKE; // [RULE_08]
          end else begin
            wcnt_q <= wcnt_q + `QUG_WCNT_W'(1);
          end
        end
        default: state_q <= qug_pkg::ST_AWAKE;
      endcase
    end
  end
  assign o_osc_run = (state_q != qug_pkg::ST_ASLEEP); // [RULE_04]
  assign o_uart_ready = (state_q == qug_pkg::ST_AWAKE); // [RULE_08]

  // a fresh wake beats a summary read in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      wake_irq_q <= 1'b0;
    end else if (state_q == qug_pkg::ST_ASLEEP && wake_ev) begin
      wake_irq_q <= 1'b1; // [RULE_09]
    end else if (i_summary_rd) begin
      wake_irq_q <= 1'b0; // [RULE_09]
    end
  end
  assign o_wake_irq = wake_irq_q;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // unmapped addresses and write-only or reserved bits read as zero
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `QUG_OFF_CTRL: begin
          rdata_q <= {4'h0, sleep_en_q, 24'h00_0000}; // [RULE_10]
        end
        `QUG_OFF_IDENT: begin
          rdata_q <= {8'h00, i_ee_din, 6'h00, bcast_q, // [RULE_15]
                      SERIES, 4'h4, REVISION}; // [RULE_11] [RULE_12]
        end
        `QUG_OFF_PIN: rdata_q <= {pin_q.invert, pin_q.tristate,
                                  pin_rd_lvl, pin_q.irq_en};
        `QUG_OFF_PINSEL: rdata_q <= {24'h00_0000, pin_q.direction};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end
  assign o_reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  // helper for the checks: cycles spent running but not yet ready; a long
  // window is counted here because a repetition that long would not unroll
  logic [`QUG_WCNT_W-1:0] wake_gap_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || o_uart_ready || !o_osc_run) begin
      wake_gap_q <= '0;
    end else if (wake_gap_q != '1) begin
      wake_gap_q <= wake_gap_q + `QUG_WCNT_W'(1);
    end
  end
  logic chan_rst_wr;
  assign chan_rst_wr = wr_ctrl && i_reg_be[2];

  sequence s_asleep_wake;
    state_q == qug_pkg::ST_ASLEEP && wake_ev;
  endsequence
  sequence s_fall_asleep;
    state_q == qug_pkg::ST_AWAKE ##1 state_q == qug_pkg::ST_ASLEEP;
  endsequence
  // ready may only rise once the whole wake window has run out
  sequence s_ready_at_end;
    ##31 !o_uart_ready ##1 o_uart_ready;
  endsequence

  // back-to-back reset writes may legally keep the pulse up a second cycle
  reset_pulse_a: assert property (chan_rst_wr |=> // [RULE_01] [RULE_02]
    o_chan_reset == $past(i_reg_wdata[19:16]) ##1
    (o_chan_reset == 4'h0 || $past(chan_rst_wr)))
    else $error("channel reset not a one-cycle pulse");
  sleep_entry_a: assert property (s_fall_asleep |-> // [RULE_03]
    $past(sleep_en_q) == `QUG_SLEEP_ALL && $past(i_int_summary) == 4'h0 &&
    $past(i_divisor_nonzero) == 4'hF && $past(i_rx_in) == 4'hF &&
    $past(i_modem_delta) == 4'h0)
    else $error("sleep entered while not allowed");
  osc_halt_a: assert property (state_q == qug_pkg::ST_ASLEEP && // [RULE_04]
    !wake_ev |=> !o_osc_run)
    else $error("oscillator restarted without a wake event");
  wake_seq_a: assert property (s_asleep_wake |=> // [RULE_05]
    (state_q == qug_pkg::ST_WAKING && !o_uart_ready) [*8])
    else $error("wake event ignored");
  wake_time_a: assert property (s_asleep_wake |=> s_ready_at_end) // [RULE_08]
    else $error("uart not ready 32 clocks after wake");
  wake_window_a: assert property ( // [RULE_08]
    wake_gap_q <= `QUG_WCNT_W'(`QUG_WAKE_CLKS))
    else $error("wake window longer than 32 clocks");
  wake_irq_a: assert property (s_asleep_wake |=> o_wake_irq) // [RULE_09]
    else $error("no special interrupt on wake");
  pin_clear_a: assert property ( // [RULE_20]
    rd_pin_lvl && !pin_rise |=> !o_pin_irq)
    else $error("pin interrupt survives level read");
  pin_code_a: assert property ( // [RULE_19]
    o_pin_irq |-> o_ch0_src_code == 3'h6)
    else $error("pin interrupt code wrong");
  ee_hold_a: assert property (!(wr_ident && i_reg_be[2]) |=> // [RULE_21]
    $stable({o_ee_clk, o_ee_cs, o_ee_dout}))
    else $error("eeprom bits changed without write");
endmodule

// file: verilog/qug_params.svh
// constants for the quad uart global control block
`ifndef QUG_PARAMS_SVH
`define QUG_PARAMS_SVH
`define QUG_OFF_CTRL 8'h00
`define QUG_OFF_IDENT 8'h04
`define QUG_OFF_PIN 8'h08
`define QUG_OFF_PINSEL 8'h0C
`define QUG_BCAST_BIT 16
`define QUG_EE_CLK_BIT 20
`define QUG_EE_CS_BIT 21
`define QUG_EE_DO_BIT 22
`define QUG_EE_DI_BIT 23
`define QUG_SLEEP_RST 4'h0
`define QUG_SLEEP_ALL 4'hF
`define QUG_PINSEL_RST 8'hFF
`define QUG_PIN_RST 8'h00
`define QUG_PIN_CODE 3'h6
`define QUG_WAKE_CLKS 32
`define QUG_WCNT_W 6
`endif

// file: verilog/qug_pkg.sv
// types shared by the quad uart global control block
package qug_pkg;
  typedef enum logic [1:0] {
    ST_AWAKE,
    ST_ASLEEP,
    ST_WAKING
  } qug_state_t;

  typedef struct packed {
    logic [7:0] irq_en;
    logic [7:0] level;
    logic [7:0] tristate;
    logic [7:0] invert;
    logic [7:0] direction;
  } qug_pin_cfg_t;

  typedef struct packed {
    logic clk;
    logic cs;
    logic dout;
  } qug_eeprom_t;
endpackage

// file: test/qug_uart_side_model.sv
// far-side model: channel modem delta latches and eeprom data pin
`timescale 1ns/1ps
module qug_uart_side_model (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [15:0] i_modem_in,
  input wire logic i_msr_rd,
  input wire logic i_ee_cs,
  input wire logic i_ee_dout,
  output logic [3:0] o_modem_delta,
  output logic o_ee_din
);
  logic [15:0] modem_q;
  // delta stays set until the host reads modem status, which blocks sleep
  always_ff @(posedge i_ref_clk) begin
    modem_q <= i_modem_in;
    for (int c = 0; c < 4; c++) begin
      if (i_srst || i_msr_rd) begin
        o_modem_delta[c] <= 1'b0;
      end else if (i_modem_in[4*c+:4] != modem_q[4*c+:4]) begin
        o_modem_delta[c] <= 1'b1;
      end
    end
  end
  // unselected pin is not held: it toggles so a stale level cannot pass
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_ee_din <= 1'b0;
    end else begin
      o_ee_din <= i_ee_cs ? ~i_ee_dout : ~o_ee_din;
    end
  end
endmodule

// file: test/tb.sv
// self-checking bench for the quad uart global control block
`timescale 1ns/1ps
module tb;
  logic clk, srst, wr, rd, summary_rd, msr_rd, ee_din, rd_pend;
  logic [7:0] addr, pin, pin_out, pin_oe;
  logic [3:0] be, summary, divnz, delta, rx, tx_load, chan_rst;
  logic [31:0] wdata, rdata, rnd, lvl;
  logic [15:0] modem;
  logic [2:0] src_in, src_out;
  logic bcast, osc_run, ready, wake_irq, ee_clk, ee_cs, ee_dout, pin_irq;
  logic [31:0] exp_q[$];
  logic [31:0] rst_q[$];
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  // identity values below are arbitrary
  qug_global_ctrl #(.SERIES(4'h3), .REVISION(8'h07)) uut (
    .i_ref_clk(clk), .i_srst(srst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_be(be), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .i_int_summary(summary),
    .i_summary_rd(summary_rd), .i_divisor_nonzero(divnz),
    .i_modem_delta(delta), .i_rx_in(rx), .i_tx_load(tx_load),
    .i_modem_in(modem), .i_ch0_src_code(src_in), .o_ch0_src_code(src_out),
    .o_chan_reset(chan_rst), .o_broadcast(bcast), .o_osc_run(osc_run),
    .o_uart_ready(ready), .o_wake_irq(wake_irq), .o_ee_clk(ee_clk),
    .o_ee_cs(ee_cs), .o_ee_dout(ee_dout), .i_ee_din(ee_din),
    .i_pin(pin), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
    .o_pin_irq(pin_irq));
  qug_uart_side_model side (
    .i_ref_clk(clk), .i_srst(srst), .i_modem_in(modem), .i_msr_rd(msr_rd),
    .i_ee_cs(ee_cs), .i_ee_dout(ee_dout), .o_modem_delta(delta),
    .o_ee_din(ee_din));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // idle cycle after each access keeps strobes from toggling in one step
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [3:0] b, input logic [31:0] d);
    wr = w;
    rd = ~w;
    addr = a;
    be = b;
    wdata = d;
    tick(1);
    wr = 1'b0;
    rd = 1'b0;
    tick(1);
  endtask
  task automatic rd32(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 4'hF, 32'h0);
  endtask
  task automatic wrap_up();
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // result watcher and timeout
  // ----------------------------------------
  always @(posedge clk) begin
    rd_pend <= rd;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      wrap_up();
    end
  end
  // a reset pulse longer than one cycle finds the queue empty and fails
  always @(negedge clk) begin
    if (rd_pend) chk("rdata", exp_q.pop_front(), rdata);
    if (chan_rst !== 4'h0) chk("chan_reset",
      rst_q.size() ? rst_q.pop_front() : 32'h0, {28'h0, chan_rst});
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    srst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    be = 4'h0;
    wdata = 32'h0000_0000;
    summary = 4'h0;
    summary_rd = 1'b0;
    divnz = 4'hF;
    rx = 4'hF;
    tx_load = 4'h0;
    modem = 16'h0000;
    msr_rd = 1'b0;
    src_in = 3'h3;
    pin = 8'h00;
    rnd = 32'h0000_0034; // xorshift seed, 52
    tick(8);
    srst = 0;
    rd32(8'h00, 32'h0);
    rd32(8'h04, {ee_din, 15'h0, 8'h34, 8'h07});
    rd32(8'h0C, 32'h000000FF);
    rd32(8'h10, 32'h0);
    chk("ee_out", 32'h0, {29'h0, ee_clk, ee_cs, ee_dout});
    for (int c = 0; c < 4; c++) begin
      rst_q.push_back(32'h1 << c);
      bus(1, 8'h00, 4'h4, 32'h1 << (16 + c));
    end
    for (int i = 0; i < 6; i++) begin
      rnd = xs(rnd);
      bus(1, 8'h04, 4'h4, rnd & 32'h00770000);
      chk("bcast_ee", {28'h0, rnd[16], rnd[20], rnd[21], rnd[22]},
          {28'h0, bcast, ee_clk, ee_cs, ee_dout});
      rd32(8'h04, {8'h00, ee_din, 6'h00, rnd[16], 8'h34, 8'h07});
    end
    // each pass spoils one sleep condition
    for (int k = 0; k < 4; k++) begin
      rnd = xs(rnd);
      summary = (k == 0) ? (rnd[3:0] | 4'h1) : 4'h0;
      divnz = (k == 1) ? 4'hB : 4'hF;
      rx = (k == 2) ? 4'h7 : 4'hF;
      bus(1, 8'h00, 4'h8, (k == 3) ? 32'h07000000 : 32'h0F000000);
      tick(3);
      chk("osc_run", 32'h1, {31'h0, osc_run});
      bus(1, 8'h00, 4'h8, 32'h0);
    end
    bus(1, 8'h00, 4'h8, 32'hFF000000);
    rd32(8'h00, 32'h0F000000);
    tick(2);
    chk("osc_run", 32'h0, {31'h0, osc_run});
    for (int w = 0; w < 3; w++) begin
      if (w == 0) rx = 4'hB;
      if (w == 1) tx_load = 4'h4;
      if (w == 2) modem = 16'h0100;
      tick(1);
      rx = 4'hF;
      tx_load = 4'h0;
      chk("wake", 32'h6, {29'h0, osc_run, wake_irq, ready});
      tick(30);
      chk("ready", 32'h0, {31'h0, ready});
      tick(3);
      chk("ready", 32'h1, {31'h0, ready});
      summary_rd = 1;
      tick(1);
      summary_rd = 0;
      tick(2);
      chk("wake_irq", 32'h0, {31'h0, wake_irq});
      chk("osc_run", (w == 2), {31'h0, osc_run});
      msr_rd = 1;
      tick(1);
      msr_rd = 0;
      tick(3);
      chk("osc_run", 32'h0, {31'h0, osc_run});
    end
    bus(1, 8'h00, 4'h8, 32'h0);
    // pins 3:0 inputs with irq, 7:4 outputs, pin 6 tri-stated
    bus(1, 8'h0C, 4'h1, 32'h0F);
    bus(1, 8'h08, 4'hF, 32'h0340A5FF);
    tick(2);
    chk("pin_irq", 32'hE, {28'h0, pin_irq, src_out});
    lvl = {24'h0, ((pin ^ 8'h03) & 8'h0F) | 8'hA0};
    rd32(8'h08, {8'h03, 8'h40, lvl[7:0], 8'hFF});
    chk("pin_drive", 32'hB0A5, {16'h0, pin_oe, pin_out});
    chk("pin_irq", 32'h3, {28'h0, pin_irq, src_out});
    pin = 8'h20;
    tick(2);
    chk("pin_irq", 32'h3, {28'h0, pin_irq, src_out});
    pin = 8'h24;
    tick(2);
    chk("pin_irq", 32'hE, {28'h0, pin_irq, src_out});
    lvl = {24'h0, ((pin ^ 8'h03) & 8'h0F) | 8'hA0};
    rd32(8'h08, {8'h03, 8'h40, lvl[7:0], 8'hFF});
    chk("pin_irq", 32'h3, {28'h0, pin_irq, src_out});
    chk("queues", 32'h0, rst_q.size() + exp_q.size());
    wrap_up();
  end
endmodule
